// *** common/pbw_pkg.sv ***
// Contract
// - Selector one: use receive queue head packet
// - Selector zero: use packet number select
// - Read data valid within 1.218 us
// - Write data committed within 2.520 us
// - Sequential window access within 588 ns
// - Auto-advance reads sustain one per cycle
// - Write direction accepts writes at once
// - Low pointer holds offset bits 7:0
// - High pointer: selector, advance, direction, offset
// - Offset applied when high follows low
// - Read direction starts read prefetch at once
// - Low pointer reads last buffer address used
package pbw_pkg;
  // Register addresses on the core data bus
  localparam logic [15:0] ADDR_WINDOW   = 16'h6000;
  localparam logic [15:0] ADDR_OFF_LOW  = 16'h7f50;
  localparam logic [15:0] ADDR_OFF_HIGH = 16'h7f51;
  // Field positions of byte_offset_high
  localparam int HIGH_RCV_BIT  = 7;
  localparam int HIGH_AUTO_BIT = 6;
  localparam int HIGH_DIR_BIT  = 5;
  localparam int HIGH_OFF_MSB  = 2;
  // Widths, depths and reset values
  localparam int OFFSET_W = 11;
  localparam int PKT_W    = 8;
  localparam int DATA_W   = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW  = 2;
  localparam int FIFO_CW  = 3;
  localparam logic [3:0] FILL_DEEP    = 4'h4;
  localparam logic [3:0] FILL_SHALLOW = 4'h1;
  localparam logic [10:0] OFFSET_MAX  = 11'h4fd;
  localparam logic [10:0] OFFSET_RESET = 11'h000;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [1:0]  RR_RESET    = 2'h0;
  // Timing, longest times rounded down to cycles
  localparam int CLK_PERIOD_NS   = 8;
  localparam int READ_VALID_NS   = 1218;
  localparam int WRITE_COMMIT_NS = 2520;
  localparam int SEQ_ACCESS_NS   = 588;
  localparam int READ_VALID_CYC   = READ_VALID_NS / CLK_PERIOD_NS;
  localparam int WRITE_COMMIT_CYC = WRITE_COMMIT_NS / CLK_PERIOD_NS;
  localparam int SEQ_ACCESS_CYC   = SEQ_ACCESS_NS / CLK_PERIOD_NS;

  // Entry of the write FIFO
  typedef struct packed {
    logic [PKT_W-1:0]    pkt;
    logic [OFFSET_W-1:0] off;
    logic [DATA_W-1:0]   data;
  } pbw_wr_entry_type;

  // Command to the buffer RAM; read data returns the cycle after en
  typedef struct packed {
    logic                      en;
    logic                      we;
    logic [PKT_W+OFFSET_W-1:0] addr;
    logic [DATA_W-1:0]         wdata;
  } pbw_ram_cmd_type;

  // Offset advance, wrapping past the largest packet offset
  function automatic logic [10:0] pbw_next_offset(input logic [10:0] x);
    return (x == OFFSET_MAX) ? OFFSET_RESET : 11'(x + 11'h001);
  endfunction
endpackage

// *** rtl/pbw_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbw_fifo #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic      [2:0]       count,
  output logic                  full,
  output logic                  empty
);
  logic [WIDTH-1:0] mem [pbw_pkg::FIFO_DEPTH];
  logic [1:0] wp;
  logic [1:0] rp;
  logic [2:0] cnt;
  logic [1:0] next_wp;
  logic [1:0] next_rp;
  logic [2:0] next_cnt;
  logic       do_push;
  logic       do_pop;

  // Pointer update; flush wins so stale bytes never leak out
  always_comb begin
    do_push  = push && (!full || pop) && !flush;
    do_pop   = pop && !empty && !flush;
    next_wp  = flush ? 2'h0 : (do_push ? 2'(wp + 2'h1) : wp);
    next_rp  = flush ? 2'h0 : (do_pop ? 2'(rp + 2'h1) : rp);
    next_cnt = flush ? 3'h0 :
               3'(cnt + {2'h0, do_push} - {2'h0, do_pop});
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp  <= 2'h0;
      rp  <= 2'h0;
      cnt <= 3'h0;
    end else if (ce) begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage has no reset; head always shows mem[rp], even while the FIFO is empty
  always_ff @(posedge ref_clk) begin
    if (ce && do_push) begin
      mem[wp] <= push_data;
    end
  end

  assign head  = mem[rp];
  assign count = cnt;
  assign full  = (cnt == 3'(pbw_pkg::FIFO_DEPTH));
  assign empty = (cnt == 3'h0);
endmodule // pbw_fifo
`default_nettype wire

// *** rtl/pbw_window.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbw_window (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic [15:0]            mcu_addr,
  input  wire logic                   mcu_wr,
  input  wire logic                   mcu_rd,
  input  wire logic [7:0]             mcu_wdata,
  output logic      [7:0]             mcu_rdata,
  input  wire logic [7:0]             packet_number_select,
  input  wire logic [7:0]             rxq_head,
  input  wire logic                   sie_req,
  input  wire logic                   dma_req,
  output logic                        sie_gnt,
  output logic                        dma_gnt,
  output pbw_pkg::pbw_ram_cmd_type    ram_cmd,
  input  wire logic [7:0]             ram_rdata,
  output logic                        read_ready,
  output logic                        write_busy
);
  localparam int RD_BOUND  = pbw_pkg::READ_VALID_CYC;
  localparam int WR_BOUND  = pbw_pkg::WRITE_COMMIT_CYC;
  localparam int SEQ_BOUND = pbw_pkg::SEQ_ACCESS_CYC;

  // Registered state
  logic        receive_queue_selector;
  logic        auto_advance;
  logic        dir_read;
  logic [10:0] ptr;
  logic [7:0]  low_stage;
  logic        low_pending;
  logic [10:0] last_used;
  logic [10:0] fetch_ptr;
  logic [7:0]  fetch_pkt;
  logic        infl1;
  logic        infl2;
  logic [1:0]  rr;
  // Next values
  logic        next_rcv;
  logic        next_auto;
  logic        next_dir;
  logic [10:0] next_ptr;
  logic [7:0]  next_low_stage;
  logic        next_low_pending;
  logic [10:0] next_last_used;
  logic [10:0] next_fetch_ptr;
  logic [7:0]  next_fetch_pkt;
  logic        next_infl1;
  logic        next_infl2;
  logic [1:0]  next_rr;
  logic [7:0]  next_mcu_rdata;
  logic        next_sie_gnt;
  logic        next_dma_gnt;
  pbw_pkg::pbw_ram_cmd_type next_ram_cmd;
  // Decode and datapath terms
  logic        wr_win;
  logic        rd_win;
  logic        wr_low;
  logic        wr_high;
  logic        start_fill;
  logic [10:0] new_ptr;
  logic [7:0]  sel_pkt;
  logic [3:0]  occupancy;
  logic        fetch_need;
  logic        win_req;
  logic        win_gnt;
  logic [2:0]  req;
  logic [1:0]  idx;
  logic [1:0]  gsel;
  logic        found;
  // FIFO ports
  pbw_pkg::pbw_wr_entry_type wf_push_data;
  pbw_pkg::pbw_wr_entry_type wf_head;
  logic [$bits(pbw_pkg::pbw_wr_entry_type)-1:0] wf_head_bits;
  logic        wf_empty;
  logic        wf_full;
  logic        wf_pop;
  logic        rf_push;
  logic        rf_pop;
  logic        rf_empty;
  logic [2:0]  rf_count;
  logic [7:0]  rf_head;

  // Write FIFO: core writes queue here until the arbiter commits them
  pbw_fifo #(
    .WIDTH($bits(pbw_pkg::pbw_wr_entry_type))
  ) u_wr_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .ce       (ce),
    .flush    (1'b0),
    .push     (wr_win && !dir_read),
    .push_data(wf_push_data),
    .pop      (wf_pop),
    .head     (wf_head_bits),
    .count    (),
    .full     (wf_full),
    .empty    (wf_empty)
  );
  assign wf_head = pbw_pkg::pbw_wr_entry_type'(wf_head_bits);

  // Read FIFO: prefetched bytes wait for the core here
  pbw_fifo #(
    .WIDTH(8)
  ) u_rd_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .ce       (ce),
    .flush    (start_fill),
    .push     (rf_push),
    .push_data(ram_rdata),
    .pop      (rf_pop),
    .head     (rf_head),
    .count    (rf_count),
    .full     (),
    .empty    (rf_empty)
  );

  // Bus decode and packet selection
  always_comb begin
    wr_win  = mcu_wr && (mcu_addr == pbw_pkg::ADDR_WINDOW);
    rd_win  = mcu_rd && (mcu_addr == pbw_pkg::ADDR_WINDOW);
    wr_low  = mcu_wr && (mcu_addr == pbw_pkg::ADDR_OFF_LOW);
    wr_high = mcu_wr && (mcu_addr == pbw_pkg::ADDR_OFF_HIGH);
    sel_pkt = receive_queue_selector ? rxq_head : packet_number_select;
    new_ptr = low_pending ? {mcu_wdata[pbw_pkg::HIGH_OFF_MSB:0], low_stage}
                          : ptr;
    start_fill = wr_high && mcu_wdata[pbw_pkg::HIGH_DIR_BIT];
    wf_push_data = '{pkt: sel_pkt, off: ptr, data: mcu_wdata};
    rf_pop  = rd_win && dir_read && auto_advance;
  end

  // Prefetch demand: deep in auto-advance, one byte otherwise
  always_comb begin
    occupancy  = 4'(rf_count) + {3'h0, infl1} + {3'h0, infl2};
    fetch_need = dir_read && wf_empty && !start_fill &&
                 (occupancy < (auto_advance ? pbw_pkg::FILL_DEEP
                                            : pbw_pkg::FILL_SHALLOW));
    win_req    = (!wf_empty || fetch_need) && !start_fill;
    rf_push    = infl2 && !start_fill;
  end

  // Rotating priority so no requester waits more than two slots
  always_comb begin
    req   = {dma_req, sie_req, win_req};
    found = 1'b0;
    gsel  = 2'h0;
    idx   = 2'h0;
    for (int i = 0; i < 3; i++) begin
      idx = 2'((int'(rr) + i) % 3);
      if (!found && req[idx]) begin
        found = 1'b1;
        gsel  = idx;
      end
    end
    win_gnt      = found && (gsel == 2'h0);
    next_sie_gnt = found && (gsel == 2'h1);
    next_dma_gnt = found && (gsel == 2'h2);
    next_rr      = found ? ((gsel == 2'h2) ? 2'h0 : 2'(gsel + 2'h1)) : rr;
    wf_pop       = win_gnt && !wf_empty;
  end

  // Register file, pointer and RAM command next values
  always_comb begin
    next_rcv         = receive_queue_selector;
    next_auto        = auto_advance;
    next_dir         = dir_read;
    next_ptr         = ptr;
    next_low_stage   = low_stage;
    next_low_pending = low_pending;
    next_last_used   = last_used;
    next_fetch_ptr   = fetch_ptr;
    next_fetch_pkt   = fetch_pkt;
    next_mcu_rdata   = mcu_rdata;
    next_infl1       = win_gnt && wf_empty && !start_fill;
    next_infl2       = infl1 && !start_fill;
    next_ram_cmd     = '{en: win_gnt, we: !wf_empty,
                         addr: {fetch_pkt, fetch_ptr},
                         wdata: wf_head.data};
    if (!wf_empty) begin
      next_ram_cmd.addr = {wf_head.pkt, wf_head.off};
    end
    // Readback is the offset of the last real RAM access
    if (win_gnt) begin
      next_last_used = next_ram_cmd.addr[10:0];
      if (wf_empty && auto_advance) begin
        next_fetch_ptr = pbw_pkg::pbw_next_offset(fetch_ptr);
      end
    end
    if (wr_low) begin
      next_low_stage   = mcu_wdata;
      next_low_pending = 1'b1;
    end
    if (wr_high) begin
      next_rcv         = mcu_wdata[pbw_pkg::HIGH_RCV_BIT];
      next_auto        = mcu_wdata[pbw_pkg::HIGH_AUTO_BIT];
      next_dir         = mcu_wdata[pbw_pkg::HIGH_DIR_BIT];
      next_ptr         = new_ptr;
      next_low_pending = 1'b0;
      next_fetch_ptr   = new_ptr;
      next_fetch_pkt   = mcu_wdata[pbw_pkg::HIGH_RCV_BIT] ? rxq_head
                                                          : packet_number_select;
    end
    // Each window read, and each window write in write direction, advances the pointer when auto-advance is on
    if ((wr_win && !dir_read) || rd_win) begin
      if (auto_advance) begin
        next_ptr = pbw_pkg::pbw_next_offset(ptr);
      end
    end
    if (mcu_rd) begin
      unique case (mcu_addr)
        pbw_pkg::ADDR_WINDOW:   next_mcu_rdata = dir_read ? rf_head
                                                          : pbw_pkg::DATA_RESET;
        pbw_pkg::ADDR_OFF_LOW:  next_mcu_rdata = last_used[7:0];
        pbw_pkg::ADDR_OFF_HIGH: next_mcu_rdata = {receive_queue_selector,
                                  auto_advance, dir_read, 2'h0,
                                  ptr[10:8]};
        default:                next_mcu_rdata = pbw_pkg::DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      receive_queue_selector <= 1'b0;
      auto_advance <= 1'b0;
      dir_read     <= 1'b0;
      ptr          <= pbw_pkg::OFFSET_RESET;
      low_stage    <= pbw_pkg::DATA_RESET;
      low_pending  <= 1'b0;
      last_used    <= pbw_pkg::OFFSET_RESET;
      fetch_ptr    <= pbw_pkg::OFFSET_RESET;
      fetch_pkt    <= pbw_pkg::DATA_RESET;
      infl1        <= 1'b0;
      infl2        <= 1'b0;
      rr           <= pbw_pkg::RR_RESET;
      mcu_rdata    <= pbw_pkg::DATA_RESET;
      sie_gnt      <= 1'b0;
      dma_gnt      <= 1'b0;
      ram_cmd      <= '0;
      read_ready   <= 1'b0;
      write_busy   <= 1'b0;
    end else if (ce) begin
      receive_queue_selector <= next_rcv;
      auto_advance <= next_auto;
      dir_read     <= next_dir;
      ptr          <= next_ptr;
      low_stage    <= next_low_stage;
      low_pending  <= next_low_pending;
      last_used    <= next_last_used;
      fetch_ptr    <= next_fetch_ptr;
      fetch_pkt    <= next_fetch_pkt;
      infl1        <= next_infl1;
      infl2        <= next_infl2;
      rr           <= next_rr;
      mcu_rdata    <= next_mcu_rdata;
      sie_gnt      <= next_sie_gnt;
      dma_gnt      <= next_dma_gnt;
      ram_cmd      <= next_ram_cmd;
      read_ready   <= !rf_empty;
      write_busy   <= !wf_empty;
    end
  end

  // Wait counters for the timing checks
  logic [9:0] wr_busy_cyc;
  logic [9:0] win_wait_cyc;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_busy_cyc  <= 10'h000;
      win_wait_cyc <= 10'h000;
    end else if (ce) begin
      wr_busy_cyc  <= wf_pop ? 10'h000 : (!wf_empty ? 10'(wr_busy_cyc + 10'h1)
                                                    : 10'h000);
      win_wait_cyc <= (win_req && !win_gnt) ? 10'(win_wait_cyc + 10'h1)
                                            : 10'h000;
    end
  end

  property p_rcv_head;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && wr_high && mcu_wdata[7]) |=> (fetch_pkt == $past(rxq_head));
  endproperty
  a_rcv_head: assert property (p_rcv_head) else $error("head packet not used");
  property p_pns_sel;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && wr_win && !dir_read && !receive_queue_selector) |->
      (wf_push_data.pkt == packet_number_select);
  endproperty
  a_pns_sel: assert property (p_pns_sel) else $error("wrong write packet");
  // Bounded by the 1.218 us read valid limit (152 cycles), not by the usual few cycles
  property p_read_valid;
    @(posedge ref_clk) disable iff (!rstn || !ce)
    (start_fill && wf_empty) |-> ##[1:RD_BOUND] read_ready;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read fifo slow");
  property p_fill_time;
    @(posedge ref_clk) disable iff (!rstn || !ce)
    (start_fill && !wf_empty == 1'b0) ##1 !mcu_wr [*8] |-> read_ready;
  endproperty
  a_fill_time: assert property (p_fill_time) else $error("read data late");
  property p_commit;
    @(posedge ref_clk) disable iff (!rstn)
    wr_busy_cyc <= 10'(WR_BOUND);
  endproperty
  a_commit: assert property (p_commit) else $error("write commit late");
  property p_seq;
    @(posedge ref_clk) disable iff (!rstn)
    win_wait_cyc < 10'(SEQ_BOUND);
  endproperty
  a_seq: assert property (p_seq) else $error("window access late");
  property p_arb;
    @(posedge ref_clk) disable iff (!rstn || !ce)
    win_req |-> ##[0:2] win_gnt;
  endproperty
  a_arb: assert property (p_arb) else $error("window starved");
  property p_ptr_apply;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && wr_high && low_pending) |=>
      (ptr == {$past(mcu_wdata[2:0]), $past(low_stage)}) && !low_pending;
  endproperty
  a_ptr_apply: assert property (p_ptr_apply) else $error("offset not applied");
  property p_ptr_hold;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && wr_high && !low_pending) |=> (ptr == $past(ptr));
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("offset moved");
  property p_advance;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && rd_win && auto_advance) |=>
      (ptr == pbw_pkg::pbw_next_offset($past(ptr)));
  endproperty
  a_advance: assert property (p_advance) else $error("no auto-advance");
  property p_write_take;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && wr_win && !dir_read && !wf_full) |=> ##1 write_busy;
  endproperty
  a_write_take: assert property (p_write_take) else $error("write dropped");
  property p_high_read;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && mcu_rd && mcu_addr == pbw_pkg::ADDR_OFF_HIGH) |=>
      (mcu_rdata[7:5] == $past({receive_queue_selector, auto_advance,
                                dir_read})) && (mcu_rdata[2:0] == $past(ptr[10:8]));
  endproperty
  a_high_read: assert property (p_high_read) else $error("high readback");
  property p_last_used;
    @(posedge ref_clk) disable iff (!rstn)
    ram_cmd.en |-> (last_used == ram_cmd.addr[10:0]);
  endproperty
  a_last_used: assert property (p_last_used) else $error("readback stale");
  property p_fill_start;
    @(posedge ref_clk) disable iff (!rstn)
    (ce && start_fill) |=> (fetch_ptr == ptr) && dir_read;
  endproperty
  a_fill_start: assert property (p_fill_start) else $error("fill not started");
  c_read: cover property (@(posedge ref_clk) start_fill ##[1:40] rf_pop);
  c_write: cover property (@(posedge ref_clk) wf_pop && ram_cmd.en);
  c_contend: cover property (@(posedge ref_clk) sie_req && dma_req && win_req);
endmodule // pbw_window
`default_nettype wire

// *** testbench/pbw_ram_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbw_ram_model (
  input  wire pbw_pkg::pbw_ram_cmd_type ram_cmd,
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  output var  logic [7:0]               ram_rdata,
  output var  int                       wr_count
);
  logic [7:0] mem [int];

  // Read data one cycle after en; outside that the line toggles every cycle
  // so that a stale byte never passes for a fresh one
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ram_rdata <= 8'h00;
      wr_count  <= 0;
    end else if (ram_cmd.en && ram_cmd.we) begin
      mem[int'(ram_cmd.addr)] = ram_cmd.wdata;
      wr_count  <= wr_count + 1;
      ram_rdata <= ~ram_rdata;
    end else if (ram_cmd.en && mem.exists(int'(ram_cmd.addr))) begin
      ram_rdata <= mem[int'(ram_cmd.addr)];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule // pbw_ram_model
`default_nettype wire

// *** testbench/tb_pbw_window.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_pbw_window;
  logic                     ref_clk, rstn, ce, mcu_wr, mcu_rd;
  logic [15:0]              mcu_addr;
  logic [7:0]               mcu_wdata, mcu_rdata, packet_number_select;
  logic [7:0]               rxq_head, ram_rdata, p, q, v1, v2;
  logic                     sie_req, dma_req, sie_gnt, dma_gnt;
  logic                     read_ready, write_busy, go, rd_pend;
  logic                     gnt_chk, sie_q, dma_q;
  pbw_pkg::pbw_ram_cmd_type ram_cmd;
  logic [7:0]               d [4];
  logic [7:0]               exp_q [$];
  logic [10:0]              o;
  int                       i, wc, wr_count, cyc;
  int                       fail_count, n_compared;

  pbw_window uut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .mcu_addr(mcu_addr), .mcu_wr(mcu_wr), .mcu_rd(mcu_rd),
    .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata),
    .packet_number_select(packet_number_select), .rxq_head(rxq_head),
    .sie_req(sie_req), .dma_req(dma_req), .sie_gnt(sie_gnt),
    .dma_gnt(dma_gnt), .ram_cmd(ram_cmd), .ram_rdata(ram_rdata),
    .read_ready(read_ready), .write_busy(write_busy));
  pbw_ram_model ram (.ref_clk(ref_clk), .rstn(rstn), .ram_cmd(ram_cmd),
    .ram_rdata(ram_rdata), .wr_count(wr_count));

  // Clock at 8 ns period
  always #4 ref_clk = ~ref_clk;

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check_byte(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One strobe cycle; strobes stay up so accesses can run back to back
  task acc(input logic w, input logic [15:0] a, input logic [7:0] x);
    mcu_wr    = w;
    mcu_rd    = !w;
    mcu_addr  = a;
    mcu_wdata = x;
    if (!w)
      exp_q.push_back(x);
    @(posedge ref_clk);
    #1;
  endtask

  task idle;
    mcu_wr = 1'b0;
    mcu_rd = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task wr1(input logic [15:0] a, input logic [7:0] x);
    acc(1'b1, a, x);
    idle();
  endtask

  // Bounded wait: read_ready high (rd) or write_busy low (!rd)
  task wait_for(input logic rd, input int lim);
    int n;
    n = 0;
    while (n < lim && (rd ? read_ready !== 1'b1 : write_busy !== 1'b0)) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("wrong value at %0t: flag wait ran out", $time);
    end
  endtask

  // Flush shows a cycle late, so skip 3 edges; pad to 24 core cycles
  task settle;
    repeat (3) @(posedge ref_clk);
    #1;
    wait_for(1'b1, pbw_pkg::READ_VALID_CYC - 3);
    repeat (21) @(posedge ref_clk);
    #1;
  endtask

  // Result monitor: a read answers on the edge after its strobe
  always @(posedge ref_clk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0)
        check_byte(8'h00, 8'hxx);
      else
        check_byte(exp_q.pop_front(), mcu_rdata);
    end
    rd_pend = (mcu_rd === 1'b1) && rstn;
  end

  // Grants follow a request one edge earlier, one requester per slot;
  // skipped after a frozen edge, since grants then keep their old value
  always @(posedge ref_clk) begin
    if (gnt_chk)
      check_byte(8'h00, {5'h00, sie_gnt && !sie_q, dma_gnt && !dma_q,
        (sie_gnt || dma_gnt) && (ram_cmd.en || (sie_gnt && dma_gnt))});
    gnt_chk = go && ce && rstn;
    sie_q   = sie_req;
    dma_q   = dma_req;
  end

  // Contending requesters keep the arbiter busy all run long
  always @(posedge ref_clk) begin
    if (go) begin
      #1;
      sie_req = 1'($urandom);
      dma_req = 1'($urandom);
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  initial begin
    {ref_clk, rstn, mcu_wr, mcu_rd, go, rd_pend, sie_req, dma_req} = '0;
    {mcu_addr, mcu_wdata, packet_number_select, rxq_head} = '0;
    {gnt_chk, sie_q, dma_q} = '0;
    ce = 1'b1;
    void'($urandom(32'hb8fe_cfb0));
    repeat (8) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    go   = 1'b1;
    // Reset values, an unmapped address, window read in write mode
    acc(1'b0, pbw_pkg::ADDR_OFF_LOW, 8'h00);
    acc(1'b0, pbw_pkg::ADDR_OFF_HIGH, 8'h00);
    acc(1'b0, 16'h1234, 8'h00);
    acc(1'b0, pbw_pkg::ADDR_WINDOW, 8'h00);
    idle();
    // Burst write across the offset wrap at the top of a packet
    p = 8'($urandom);
    packet_number_select = p;
    for (i = 0; i < 4; i++)
      d[i] = 8'($urandom);
    wr1(pbw_pkg::ADDR_OFF_LOW, 8'hfc);
    wr1(pbw_pkg::ADDR_OFF_HIGH, 8'h44);
    for (i = 0; i < 4; i++)
      acc(1'b1, pbw_pkg::ADDR_WINDOW, d[i]);
    idle();
    repeat (1) @(posedge ref_clk);
    #1;
    wait_for(1'b0, pbw_pkg::WRITE_COMMIT_CYC - 2);
    @(posedge ref_clk);
    #1;
    o = 11'h4fc;
    for (i = 0; i < 4; i++) begin
      check_byte(d[i], ram.mem[int'({p, o})]);
      o = (o == 11'h4fd) ? 11'h000 : o + 11'h001;
    end
    repeat (60) @(posedge ref_clk);
    #1;
    // Auto-advance read of the same bytes, back to back, from the select
    wr1(pbw_pkg::ADDR_OFF_LOW, 8'hfc);
    wr1(pbw_pkg::ADDR_OFF_HIGH, 8'h64);
    settle();
    for (i = 0; i < 4; i++)
      acc(1'b0, pbw_pkg::ADDR_WINDOW, d[i]);
    idle();
    // A window write in read direction never reaches the RAM
    wc = wr_count;
    wr1(pbw_pkg::ADDR_WINDOW, 8'h77);
    repeat (8) @(posedge ref_clk);
    #1;
    check_byte(8'(wc), 8'(wr_count));
    // Queue head packet, no advance; select points elsewhere
    q  = 8'($urandom);
    v1 = 8'($urandom);
    v2 = ~v1;
    rxq_head = q;
    packet_number_select = ~q;
    ram.mem[int'({q, 11'h110})] = v1;
    ram.mem[int'({q, 11'h310})] = v2;
    wr1(pbw_pkg::ADDR_OFF_LOW, 8'h10);
    wr1(pbw_pkg::ADDR_OFF_HIGH, 8'ha1);
    settle();
    acc(1'b0, pbw_pkg::ADDR_WINDOW, v1);
    acc(1'b0, pbw_pkg::ADDR_WINDOW, v1);
    acc(1'b0, pbw_pkg::ADDR_OFF_LOW, 8'h10);
    acc(1'b0, pbw_pkg::ADDR_OFF_HIGH, 8'ha1);
    idle();
    // A low write while the clock enable is low must leave no trace
    ce = 1'b0;
    wr1(pbw_pkg::ADDR_OFF_LOW, 8'h55);
    ce = 1'b1;
    // High byte alone keeps the offset; low then high applies it
    wr1(pbw_pkg::ADDR_OFF_HIGH, 8'ha3);
    settle();
    acc(1'b0, pbw_pkg::ADDR_WINDOW, v1);
    acc(1'b0, pbw_pkg::ADDR_OFF_HIGH, 8'ha1);
    idle();
    wr1(pbw_pkg::ADDR_OFF_LOW, 8'h10);
    wr1(pbw_pkg::ADDR_OFF_HIGH, 8'ha3);
    settle();
    acc(1'b0, pbw_pkg::ADDR_WINDOW, v2);
    idle();
    repeat (4) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("wrong value at %0t: reads left unanswered", $time);
    end
    wrap_up();
  end
endmodule // tb_pbw_window
`default_nettype wire
